// ===== hdl/isb_consts.svh
// Purpose: Constants for the two-wire slave front end
// Assumes: Included by bare name
// Notes: Mode codes are local encodings of the two-bit mode field
`ifndef ISB_CONSTS_SVH
`define ISB_CONSTS_SVH
// ---------------------------------------------------------------
// Modes
// ---------------------------------------------------------------
`define ISB_MODE_7BIT 2'h0
`define ISB_MODE_10BIT 2'h1
`define ISB_MODE_7BIT_SP 2'h2
`define ISB_MODE_10BIT_SP 2'h3
// ---------------------------------------------------------------
// Address and framing
// ---------------------------------------------------------------
`define ISB_TEN_HDR 5'h1e
`define ISB_ACK_BIT 4'h8
`define ISB_LAST_BIT 4'h7
`define ISB_RST_ADDR 10'h000
`endif

// ===== hdl/isb_pkg.sv
// Purpose: Types for the two-wire slave front end
// Assumes: Constants come from isb_consts.svh
// Notes: Types only
package isb_pkg;
    typedef enum logic [2:0] {
        ISB_IDLE,
        ISB_ADDR,
        ISB_ADDR_LO,
        ISB_RX,
        ISB_TX,
        ISB_IGNORE
    } isb_phase_type;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
    } isb_sync_type;

    typedef struct packed {
        isb_phase_type phase;
        logic active;
        logic low_seen;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] txsh;
        logic drive_low;
        logic ack_slot;
        logic do_ack;
        logic scl_hold;
        logic int_flag;
        logic ack_stat;
        logic ack_tim;
        logic prior;
        logic read;
        logic coll;
        logic rx_valid;
        logic [7:0] rx_buf;
        logic start_seen;
        logic stop_seen;
    } isb_state_type;
endpackage

// ===== hdl/isb_line_if.sv
// Purpose: Carries synchronised bus line levels and edges
// Assumes: Single clock domain
// Notes: Driven by the condition detector
`timescale 1ns/100ps
interface isb_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport det (output scl, sda, scl_rise, scl_fall, start_det,
        stop_det);
    modport core (input scl, sda, scl_rise, scl_fall, start_det,
        stop_det);
endinterface

// ===== hdl/isb_cond_det.sv
// Purpose: Synchronises bus lines and finds Start and Stop
// Assumes: Lines are pin inputs, asynchronous to i_sys_clk
// Notes: Stop arming is done in the core
`timescale 1ns/100ps
module isb_cond_det (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Pins
    input wire logic i_scl,
    input wire logic i_sda,
    // Line events
    isb_line_if.det lines
);
    import isb_pkg::*;
    isb_sync_type st_r;
    isb_sync_type st_nxt;

    // ---------------------------------------------------------------
    // Synchroniser, idle high at reset
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_s = {st_r.scl_s[0], i_scl};
        st_nxt.sda_s = {st_r.sda_s[0], i_sda};
        st_nxt.scl_d = st_r.scl_s[1];
        st_nxt.sda_d = st_r.sda_s[1];
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= '{2'h3, 2'h3, 1'b1, 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lines.scl = st_r.scl_s[1];
    assign lines.sda = st_r.sda_s[1];
    assign lines.scl_rise = st_r.scl_s[1] & ~st_r.scl_d;
    assign lines.scl_fall = ~st_r.scl_s[1] & st_r.scl_d;
    // Both edge terms need the clock high on both samples
    assign lines.start_det = st_r.scl_s[1] & st_r.scl_d &
        st_r.sda_d & ~st_r.sda_s[1];
    assign lines.stop_det = st_r.scl_s[1] & st_r.scl_d &
        ~st_r.sda_d & st_r.sda_s[1];

    chk_start_clk_high: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        lines.start_det |-> lines.scl && $past(lines.scl))
        else $error("start seen with clock low");
    chk_stop_rise: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        lines.stop_det |-> lines.sda && !$past(lines.sda))
        else $error("stop without data rise");
endmodule

// ===== hdl/isb_slave.sv
// Purpose: Two-wire slave front end: conditions, address, acknowledge
// Assumes: External master drives the clock; lines sampled at 25 MHz
// Notes: Byte sequencing beyond acknowledge and stretch release are
//        outside this block
//
// Functional notes
// - Bus idle while both lines high with no master; active after Start.
// - Start is data falling while clock high; master only.
// - Collision if the device is driving data low when Start is detected.
// - Collision when data is sampled low on a clock rise while transmitting a one.
// - Stop is data rising while clock high.
// - Stop accepted only after one clock-low period since Start.
// - Restart valid where Stop is; resets slave like a Start.
// - Ten-bit: matched, Restart, high byte with read holds clock.
// - Ten-bit full write match sets prior-match flag until cleared.
// - Start/Stop interrupt enables only act in modes lacking them.
// - Ninth pulse is acknowledge; transmitter releases data line.
// - Acknowledge level in slot is stored in a readable bit.
// - With hold options set, acknowledge drives software value.
// - With both hold options clear, hardware acknowledges itself.
// - No acknowledge if buffer-full or overflow already set.
// - Ack-time flag after 8th falling edge only with hold options.
// - Mode field picks one of four slave modes.
// - Start/Stop modes set interrupt flag on Start, Restart, Stop.
// - First byte compared to address; match loads buffer, interrupts.
// - No match ignores the bus until Start/Stop, with no flag.
// - Address mask selects which bits are compared.
// - After read match the slave supplies data until master not-acknowledge, Restart or Stop.
// - Seven-bit match ignores the least significant bit.
// - Ten-bit high byte compared with 11110, A2, A1, 0.
// - Data changes with clock low, sampled on rise, MSB first.
`timescale 1ns/100ps
`include "isb_consts.svh"
module isb_slave (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Bus pins, enable low while driving low
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_out,
    output logic o_scl_oe_n,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // Configuration
    input wire logic [1:0] i_port_mode_select,
    input wire logic [9:0] i_slave_address_reg,
    input wire logic [9:0] i_address_mask_reg,
    input wire logic i_address_hold_enable,
    input wire logic i_data_hold_enable,
    input wire logic i_ack_value_bit,
    input wire logic i_start_int_enable,
    input wire logic i_stop_int_enable,
    // Software status inputs
    input wire logic i_buffer_full_flag,
    input wire logic i_receive_overflow_flag,
    input wire logic i_int_clear,
    input wire logic i_hold_release,
    input wire logic [7:0] i_tx_data,
    // Status outputs
    output logic o_bus_active,
    output logic o_port_int_flag,
    output logic o_ack_status_bit,
    output logic o_ack_time_flag,
    output logic o_prior_match,
    output logic o_read_mode,
    output logic o_bus_collision,
    output logic o_rx_valid,
    output logic [7:0] o_receive_buffer,
    output logic o_start_seen,
    output logic o_stop_seen
);
    import isb_pkg::*;

    isb_state_type s_r;
    isb_state_type s_nxt;
    isb_line_if lines ();

    isb_cond_det u_det (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .lines(lines)
    );

    // ---------------------------------------------------------------
    // Address match helpers
    // ---------------------------------------------------------------
    function automatic logic match_bits(input logic [7:0] rx,
        input logic [7:0] ad, input logic [7:0] mk);
        match_bits = ((rx ^ ad) & mk) == 8'h00;
    endfunction

    function automatic logic is_ten(input logic [1:0] m);
        is_ten = (m == `ISB_MODE_10BIT) || (m == `ISB_MODE_10BIT_SP);
    endfunction

    logic ten_mode;
    logic sp_mode;
    logic hold_opt;
    logic sp_int_start;
    logic sp_int_stop;
    logic restart_ev;
    logic stop_ok;
    logic [7:0] hi_pat;
    logic [7:0] ack_byte;
    logic hw_ack;

    assign ten_mode = is_ten(i_port_mode_select);
    assign sp_mode = (i_port_mode_select == `ISB_MODE_7BIT_SP) ||
        (i_port_mode_select == `ISB_MODE_10BIT_SP);
    assign hold_opt = i_address_hold_enable | i_data_hold_enable;
    // Enables are redundant where the mode already interrupts
    assign sp_int_start = sp_mode | i_start_int_enable;
    assign sp_int_stop = sp_mode | i_stop_int_enable;
    assign stop_ok = lines.stop_det & s_r.low_seen;
    assign restart_ev = lines.start_det & s_r.active;
    assign hi_pat = {`ISB_TEN_HDR, i_slave_address_reg[2:1],
        1'b0};
    assign ack_byte = {s_r.shift[6:0], lines.sda};
    // Overflow state blocks the acknowledge whoever generates it
    assign hw_ack = ~i_buffer_full_flag &
        ~i_receive_overflow_flag;

    // ---------------------------------------------------------------
    // Main sequencer
    // ---------------------------------------------------------------
    always_comb begin
        logic match;
        logic last_rise;
        match = 1'b0;
        last_rise = lines.scl_rise && (s_r.bitcnt == `ISB_LAST_BIT);
        s_nxt = s_r;
        s_nxt.start_seen = 1'b0;
        s_nxt.stop_seen = 1'b0;
        s_nxt.rx_valid = 1'b0;
        if (i_int_clear) begin
            s_nxt.int_flag = 1'b0;
        end
        if (i_hold_release) begin
            s_nxt.scl_hold = 1'b0;
        end
        if (!lines.scl) begin
            s_nxt.low_seen = s_r.active;
        end
        // Expected high but line low while driving a one
        if (s_r.phase == ISB_TX && !s_r.ack_slot && !s_r.drive_low &&
            lines.scl_rise && !lines.sda) begin
            s_nxt.coll = 1'b1;
            s_nxt.phase = ISB_IGNORE;
        end
        if (lines.scl_rise && !s_r.ack_slot && s_r.phase != ISB_IDLE &&
            s_r.phase != ISB_IGNORE) begin
            s_nxt.shift = ack_byte;
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        if (lines.scl_fall && s_r.phase == ISB_TX && !s_r.ack_slot &&
            !s_nxt.coll) begin
            s_nxt.drive_low = ~s_r.txsh[7];
            s_nxt.txsh = {s_r.txsh[6:0], 1'b0};
        end
        // Acknowledge slot bookkeeping
        if (last_rise && s_r.phase != ISB_IDLE &&
            s_r.phase != ISB_IGNORE && s_r.phase != ISB_TX) begin
            case (s_r.phase)
                ISB_ADDR: begin
                    if (ten_mode) begin
                        match = match_bits(ack_byte & 8'hfe, hi_pat,
                            i_address_mask_reg[7:0] | 8'hf9);
                        if (!match) begin
                            s_nxt.prior = 1'b0;
                        end else if (!lines.sda) begin
                            s_nxt.prior = 1'b0;
                        end else if (!s_r.prior) begin
                            match = 1'b0;
                        end
                    end else begin
                        match = match_bits(ack_byte & 8'hfe,
                            {i_slave_address_reg[7:1], 1'b0},
                            {i_address_mask_reg[7:1], 1'b0});
                    end
                    s_nxt.read = lines.sda;
                end
                ISB_ADDR_LO: begin
                    match = match_bits(ack_byte, i_slave_address_reg[7:0],
                        i_address_mask_reg[7:0]);
                end
                ISB_RX: match = 1'b1;
                default: match = 1'b0;
            endcase
            if (match) begin
                s_nxt.ack_slot = 1'b1;
                s_nxt.do_ack = (hold_opt ? ~i_ack_value_bit : 1'b1) &
                    hw_ack;
                s_nxt.rx_buf = ack_byte;
                s_nxt.rx_valid = 1'b1;
                s_nxt.int_flag = 1'b1;
            end else begin
                s_nxt.phase = ISB_IGNORE;
            end
        end
        // Transmitted byte: release data for master's acknowledge
        if (last_rise && s_r.phase == ISB_TX) begin
            s_nxt.ack_slot = 1'b1;
            s_nxt.do_ack = 1'b0;
        end
        if (s_r.ack_slot && lines.scl_fall && !s_r.do_ack &&
            s_r.phase != ISB_TX) begin
            s_nxt.drive_low = 1'b0;
        end
        if (s_r.ack_slot && lines.scl_fall && s_r.bitcnt ==
            `ISB_LAST_BIT + 4'h1) begin
            s_nxt.drive_low = s_r.do_ack;
            // Hold only after the eighth fall, never while the clock is high
            s_nxt.ack_tim = hold_opt && s_r.phase != ISB_TX;
            s_nxt.scl_hold = s_nxt.scl_hold | s_nxt.ack_tim;
        end
        if (s_r.ack_slot && lines.scl_rise) begin
            s_nxt.ack_stat = lines.sda;
            s_nxt.bitcnt = `ISB_ACK_BIT + 4'h1;
        end
        // Leaving the slot on the ninth falling edge
        if (s_r.ack_slot && lines.scl_fall &&
            s_r.bitcnt == `ISB_ACK_BIT + 4'h1) begin
            s_nxt.ack_slot = 1'b0;
            s_nxt.ack_tim = 1'b0;
            s_nxt.bitcnt = 4'h0;
            s_nxt.drive_low = 1'b0;
            case (s_r.phase)
                ISB_ADDR: begin
                    if (s_r.read && !s_r.do_ack) begin
                        s_nxt.phase = ISB_IGNORE;
                    end else if (s_r.read) begin
                        s_nxt.phase = ISB_TX;
                        s_nxt.scl_hold = 1'b1;
                        s_nxt.drive_low = ~i_tx_data[7];
                        s_nxt.txsh = {i_tx_data[6:0], 1'b0};
                    end else begin
                        s_nxt.phase = ten_mode ? ISB_ADDR_LO : ISB_RX;
                    end
                end
                ISB_ADDR_LO: begin
                    s_nxt.phase = ISB_RX;
                    s_nxt.prior = s_r.do_ack;
                end
                ISB_TX: begin
                    if (s_r.ack_stat) begin
                        s_nxt.phase = ISB_IGNORE;
                    end else begin
                        s_nxt.drive_low = ~i_tx_data[7];
                        s_nxt.txsh = {i_tx_data[6:0], 1'b0};
                    end
                    s_nxt.int_flag = 1'b1;
                end
                default: s_nxt.phase = s_r.phase;
            endcase
        end
        // Start/Restart resets the slave logic
        if (lines.start_det) begin
            if (s_r.drive_low) begin
                s_nxt.coll = 1'b1;
            end
            s_nxt.active = 1'b1;
            s_nxt.low_seen = 1'b0;
            s_nxt.phase = ISB_ADDR;
            s_nxt.bitcnt = 4'h0;
            s_nxt.ack_slot = 1'b0;
            s_nxt.ack_tim = 1'b0;
            s_nxt.drive_low = 1'b0;
            s_nxt.scl_hold = 1'b0;
            s_nxt.start_seen = 1'b1;
            if (sp_int_start) begin
                s_nxt.int_flag = 1'b1;
            end
        end else if (stop_ok) begin
            s_nxt.active = 1'b0;
            s_nxt.low_seen = 1'b0;
            s_nxt.phase = ISB_IDLE;
            s_nxt.prior = 1'b0;
            s_nxt.ack_slot = 1'b0;
            s_nxt.ack_tim = 1'b0;
            s_nxt.drive_low = 1'b0;
            s_nxt.scl_hold = 1'b0;
            s_nxt.stop_seen = 1'b1;
            if (sp_int_stop) begin
                s_nxt.int_flag = 1'b1;
            end
        end
        if (s_nxt.phase == ISB_IGNORE) begin
            s_nxt.drive_low = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r <= '0;
            s_r.phase <= ISB_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign o_scl_out = 1'b0;
    assign o_scl_oe_n = ~s_r.scl_hold;
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = ~s_r.drive_low;
    assign o_bus_active = s_r.active;
    assign o_port_int_flag = s_r.int_flag;
    assign o_ack_status_bit = s_r.ack_stat;
    assign o_ack_time_flag = s_r.ack_tim;
    assign o_prior_match = s_r.prior;
    assign o_read_mode = s_r.read;
    assign o_bus_collision = s_r.coll;
    assign o_rx_valid = s_r.rx_valid;
    assign o_receive_buffer = s_r.rx_buf;
    assign o_start_seen = s_r.start_seen;
    assign o_stop_seen = s_r.stop_seen;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_start_goes_active: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        lines.start_det |=> o_bus_active && o_start_seen)
        else $error("start did not activate bus");
    chk_stop_needs_low: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        (lines.stop_det && !s_r.low_seen && !lines.start_det)
        |=> !o_stop_seen)
        else $error("stop taken without clock low");
    chk_stop_idle: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        (stop_ok && !lines.start_det) |=> !o_bus_active
        && !o_prior_match)
        else $error("stop did not idle bus");
    chk_restart_addr: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        restart_ev |=> s_r.phase == ISB_ADDR && s_r.bitcnt == 4'h0)
        else $error("restart did not reset slave");
    chk_ack_time_hold: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        (!hold_opt && !$past(hold_opt)) |-> !$rose(o_ack_time_flag))
        else $error("ack time flag without hold option");
    chk_sp_int: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        (lines.start_det && sp_mode) |=> o_port_int_flag)
        else $error("start interrupt missing");
    chk_nomatch_quiet: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        (s_nxt.phase == ISB_IGNORE && s_r.phase == ISB_ADDR)
        |=> !o_rx_valid)
        else $error("mismatch reported to software");
    chk_overflow_nack: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        (s_nxt.ack_slot && !s_r.ack_slot && s_r.phase != ISB_TX &&
        (i_buffer_full_flag || i_receive_overflow_flag))
        |=> !s_r.do_ack)
        else $error("acknowledge given on overflow");
    chk_ack_stored: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst)
        (s_r.ack_slot && lines.scl_rise) |=>
        o_ack_status_bit == $past(lines.sda))
        else $error("ack level not stored");
    cov_start: cover property (@(posedge i_sys_clk) o_start_seen);
    cov_stop: cover property (@(posedge i_sys_clk) o_stop_seen);
    cov_rx: cover property (@(posedge i_sys_clk) o_rx_valid);
    cov_tx: cover property (@(posedge i_sys_clk) s_r.phase == ISB_TX);
endmodule

// ===== testbench/isb_mst_model.sv
// Purpose: Behavioural two-wire bus master driving the clock line
// Assumes: Open-drain lines with pull-ups, 1 = released
// Notes: Clock stands high between frames
`timescale 1ns/100ps
module isb_mst_model (
    // Clock
    input wire logic i_sys_clk,
    // Resolved lines
    input wire logic i_scl,
    input wire logic i_sda,
    // Master pulls
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // ---------------------------------------------------------------
    // Conditions
    // ---------------------------------------------------------------
    task automatic start();
        o_sda = 1'b1;
        tk(2);
        o_scl = 1'b1;
        tk(4);
        o_sda = 1'b0;
        tk(4);
        o_scl = 1'b0;
        tk(2);
    endtask
    task automatic stop();
        o_sda = 1'b0;
        tk(2);
        o_scl = 1'b1;
        tk(4);
        o_sda = 1'b1;
        tk(4);
    endtask
    // Data fall then rise with the clock never low
    task automatic glitch();
        o_sda = 1'b0;
        tk(4);
        o_sda = 1'b1;
        tk(4);
    endtask
    // ---------------------------------------------------------------
    // Bits and bytes
    // ---------------------------------------------------------------
    // Waits out a clock hold, bounded so a stuck slave cannot hang
    task automatic bit_x(input logic b, output logic s);
        o_sda = b;
        tk(2);
        o_scl = 1'b1;
        for (int i = 0; i < 400 && i_scl !== 1'b1; i++) tk(1);
        tk(2);
        s = i_sda;
        tk(2);
        o_scl = 1'b0;
        tk(2);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(1'b1, ack);
    endtask
endmodule

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the two-wire slave front end
// Assumes: 25 MHz system clock, 320 ns bus clock
// Notes: Hold release follows any clock hold automatically
`timescale 1ns/100ps
`include "isb_consts.svh"
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, ahe = 1'b0, dhe = 1'b0, akv = 1'b0;
    logic bff = 1'b0, ovf = 1'b0, iclr = 1'b0, hrel = 1'b0;
    logic sie = 1'b0, pie = 1'b0, c_st;
    logic [9:0] msk = 10'h3ff;
    logic [7:0] txd = 8'ha5;
    logic [1:0] mode = `ISB_MODE_7BIT;
    logic m_scl, m_sda, scl_oe_n, sda_oe_n, scl_o, sda_o, act, intf;
    logic aks, atf, prm, rdm, col, rxv, sts, sps, ack, c_rx, c_sp, c_at;
    logic [7:0] rxb, q, c_b;
    wire scl_w = m_scl & (scl_oe_n | scl_o);
    wire sda_w = m_sda & (sda_oe_n | sda_o);
    int mismatches = 0, checked = 0;
    always #20 clk = ~clk;
    always @(posedge clk) hrel <= ~scl_oe_n;
    always @(posedge clk) begin
        if (rxv === 1'b1) begin
            c_rx <= 1'b1;
            c_b <= rxb;
        end
        if (sps === 1'b1) c_sp <= 1'b1;
        if (sts === 1'b1) c_st <= 1'b1;
        if (atf === 1'b1) c_at <= 1'b1;
    end
    isb_slave u_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_scl(scl_w),
        .i_sda(sda_w), .o_scl_out(scl_o), .o_scl_oe_n(scl_oe_n),
        .o_sda_out(sda_o), .o_sda_oe_n(sda_oe_n),
        .i_port_mode_select(mode), .i_slave_address_reg(10'h054),
        .i_address_mask_reg(msk), .i_address_hold_enable(ahe),
        .i_data_hold_enable(dhe), .i_ack_value_bit(akv),
        .i_start_int_enable(sie), .i_stop_int_enable(pie),
        .i_buffer_full_flag(bff), .i_receive_overflow_flag(ovf),
        .i_int_clear(iclr), .i_hold_release(hrel), .i_tx_data(txd),
        .o_bus_active(act), .o_port_int_flag(intf),
        .o_ack_status_bit(aks), .o_ack_time_flag(atf),
        .o_prior_match(prm), .o_read_mode(rdm), .o_bus_collision(col),
        .o_rx_valid(rxv), .o_receive_buffer(rxb), .o_start_seen(sts),
        .o_stop_seen(sps));
    isb_mst_model u_mst (.i_sys_clk(clk), .i_scl(scl_w), .i_sda(sda_w),
        .o_scl(m_scl), .o_sda(m_sda));
    task automatic chk1(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t bit %b want %b", $time, g, e);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t byte %h want %h", $time, g, e);
        end
    endtask
    // Clears captures and the sticky interrupt before each frame or bus sequence
    task automatic clr();
        c_rx = 1'b0;
        c_sp = 1'b0;
        c_at = 1'b0;
        c_st = 1'b0;
        iclr = 1'b1;
        u_mst.tk(1);
        iclr = 1'b0;
        u_mst.tk(2);
    endtask
    // One addressed frame, returning the acknowledge level
    task automatic frame(input logic [7:0] a);
        clr();
        u_mst.start();
        u_mst.xfer(a, q, ack);
        u_mst.stop();
        u_mst.tk(6);
    endtask
    task automatic t_write();
        frame(8'h54);
        chk1(ack, 1'b0);
        chk1(aks, 1'b0);
        chk1(c_rx, 1'b1);
        chk8(c_b, 8'h54);
        chk1(intf, 1'b1);
        chk1(c_sp, 1'b1);
        chk1(act, 1'b0);
        chk1(c_st, 1'b1);
        chk1(c_at, 1'b0);
        $display("test write done");
    endtask
    task automatic t_nomatch();
        frame(8'h56);
        chk1(ack, 1'b1);
        chk1(c_rx, 1'b0);
        chk1(intf, 1'b0);
        msk = 10'h3fb;
        frame(8'h50);
        chk1(ack, 1'b0);
        msk = 10'h3ff;
        $display("test nomatch done");
    endtask
    task automatic t_read();
        clr();
        u_mst.start();
        u_mst.xfer(8'h55, q, ack);
        chk1(ack, 1'b0);
        chk1(rdm, 1'b1);
        u_mst.xfer(8'hff, q, ack);
        chk8(q, txd);
        chk1(aks, 1'b1);
        u_mst.start();
        u_mst.xfer(8'h55, q, ack);
        u_mst.xfer(8'h00, q, ack);
        chk1(col, 1'b1);
        u_mst.stop();
        $display("test read done");
    endtask
    task automatic t_hold();
        ahe = 1'b1;
        akv = 1'b1;
        frame(8'h54);
        chk1(ack, 1'b1);
        chk1(c_at, 1'b1);
        ahe = 1'b0;
        dhe = 1'b1;
        akv = 1'b0;
        frame(8'h54);
        chk1(ack, 1'b0);
        dhe = 1'b0;
        bff = 1'b1;
        frame(8'h54);
        chk1(ack, 1'b1);
        bff = 1'b0;
        ovf = 1'b1;
        frame(8'h54);
        chk1(ack, 1'b1);
        ovf = 1'b0;
        $display("test hold done");
    endtask
    task automatic t_glitch();
        mode = `ISB_MODE_7BIT_SP;
        clr();
        u_mst.glitch();
        u_mst.tk(6);
        chk1(c_sp, 1'b0);
        chk1(intf, 1'b1);
        mode = `ISB_MODE_7BIT;
        sie = 1'b1;
        clr();
        u_mst.start();
        chk1(intf, 1'b1);
        sie = 1'b0;
        pie = 1'b1;
        clr();
        u_mst.stop();
        chk1(intf, 1'b1);
        pie = 1'b0;
        $display("test glitch done");
    endtask
    task automatic t_reset();
        nrst = 1'b0;
        u_mst.tk(2);
        nrst = 1'b1;
        u_mst.tk(4);
        chk1(col, 1'b0);
        chk1(sda_oe_n, 1'b1);
        chk1(act, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_ten();
        mode = `ISB_MODE_10BIT;
        txd = 8'h3c;
        clr();
        u_mst.start();
        u_mst.xfer(8'hf4, q, ack);
        chk1(ack, 1'b0);
        u_mst.xfer(8'h54, q, ack);
        u_mst.tk(2);
        chk1(prm, 1'b1);
        u_mst.start();
        u_mst.xfer(8'hf5, q, ack);
        chk1(ack, 1'b0);
        u_mst.xfer(8'hff, q, ack);
        chk8(q, txd);
        u_mst.stop();
        u_mst.tk(6);
        chk1(prm, 1'b0);
        mode = `ISB_MODE_7BIT;
        $display("test ten done");
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        u_mst.tk(4);
        t_write();
        t_nomatch();
        t_read();
        t_reset();
        t_hold();
        t_glitch();
        t_ten();
        tally_and_finish();
    end
    initial begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end
endmodule
